// ### design/conditional_branch_unit.sv
// Conditional relative branch unit with its APB register slave
//
// Functional notes
// RULE1 - bit-clear branch taken when selected flag clear
// RULE2 - equal branch taken when zero flag set
// RULE3 - not-equal branch taken when zero flag clear
// RULE4 - carry-set and lower taken when carry set
// RULE5 - carry-clear and same-or-higher taken when carry clear
// RULE6 - minus branch taken when negative flag set
// RULE7 - plus branch taken when negative flag clear
// RULE8 - signed greater-equal taken when N xor V clear
// RULE9 - signed less taken when N xor V set
// RULE10 - half-carry-set taken when half carry set
// RULE11 - half-carry-clear taken when half carry clear
// RULE12 - transfer-set branch taken when T flag set
// RULE13 - taken branch loads PC plus k plus one
// RULE14 - each branch completes in one or two cycles
// RULE15 - branches never change the status flags
// RULE16 - untaken takes one cycle, taken takes two
// RULE17 - offset k is sign extended before addition
`timescale 1ns/10ps
`default_nettype none
`include "branch_cfg.svh"

module conditional_branch_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`PC_W-1:0] pc_out,
    output logic busy,
    output logic branch_done
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam branch_pkg::unit_state_s STATE_RST = '{
        fsm: branch_pkg::st_idle,
        pc: `PC_RST,
        flags: `FLAGS_RST,
        op: 4'h0,
        sidx: 3'h0,
        koff: 7'h00,
        target: `PC_RST,
        taken: 1'b0,
        illegal: 1'b0,
        last_cycles: `CYC_NONE,
        done: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h00000000
    };

    branch_pkg::unit_state_s st_r;
    branch_pkg::unit_state_s st_nxt;
    logic cond_taken;
    logic cond_legal;
    logic [`PC_W-1:0] seq_pc;
    logic [`PC_W-1:0] tgt_pc;
    logic [`DATA_W-1:0] byte_mask;
    logic [`DATA_W-1:0] rd_data;
    logic [`DATA_W-1:0] wr_merge;
    logic [`DATA_W-1:0] wr_old;
    logic hit_instr;
    logic hit_pc;
    logic hit_flags;
    logic hit_status;
    logic unit_busy;
    logic acc_first;
    logic acc_commit;
    logic acc_err;

    // ----------------------------------------------------------------
    // Condition test and target arithmetic
    // ----------------------------------------------------------------
    branch_condition_eval u_cond (
        .op(st_r.op),
        .sidx(st_r.sidx),
        .flags(st_r.flags),
        .taken(cond_taken),
        .legal(cond_legal)
    );

    branch_target_adder u_adder (
        .pc(st_r.pc),
        .koff(st_r.koff),
        .next_seq(seq_pc),
        .target(tgt_pc)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------

    // Byte lane mask from write strobes
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign byte_mask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    // Address hits and phase qualifiers
    assign hit_instr = (paddr == `ADDR_INSTR);
    assign hit_pc = (paddr == `ADDR_PC);
    assign hit_flags = (paddr == `ADDR_FLAGS);
    assign hit_status = (paddr == `ADDR_STATUS);
    assign unit_busy = (st_r.fsm != branch_pkg::st_idle);
    assign acc_first = psel & penable & ~st_r.pready;
    assign acc_commit = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;

    // Read data mux, reserved bits read as zero
    always_comb
    begin
        rd_data = 32'h00000000;
        wr_old = 32'h00000000;
        if (hit_instr)
        begin
            rd_data[`INSTR_OP_LSB +: `OP_W] = st_r.op;
            rd_data[`INSTR_SIDX_LSB +: `SIDX_W] = st_r.sidx;
            rd_data[`INSTR_KOFF_LSB +: `KOFF_W] = st_r.koff;
        end
        else if (hit_pc)
        begin
            rd_data[`PC_W-1:0] = st_r.pc;
        end
        else if (hit_flags)
        begin
            rd_data[`FLAGS_W-1:0] = st_r.flags;
        end
        else if (hit_status)
        begin
            rd_data[`STAT_BUSY] = unit_busy;
            rd_data[`STAT_TAKEN] = st_r.taken;
            rd_data[`STAT_ILLEGAL] = st_r.illegal;
            rd_data[`STAT_CYC_LSB +: 2] = st_r.last_cycles;
        end
        wr_old = rd_data;
    end

    // Merge of enabled write lanes over current contents
    assign wr_merge = (wr_old & ~byte_mask) | (pwdata & byte_mask);

    // Unmapped, partial launch, or change while a branch runs
    always_comb
    begin
        acc_err = 1'b0;
        if (!(hit_instr || hit_pc || hit_flags || hit_status))
        begin
            acc_err = 1'b1;
        end
        else if (pwrite && !hit_status)
        begin
            acc_err = unit_busy; // RULE15
            if (hit_instr && ((pstrb & `INSTR_LANES) != `INSTR_LANES))
            begin
                acc_err = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Bus answer, branch sequence and register writes
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.pready = acc_first;
        if (acc_first)
        begin
            st_nxt.pslverr = acc_err;
            st_nxt.prdata = (acc_err || pwrite) ? 32'h00000000 : rd_data;
        end
        unique case (st_r.fsm)
            branch_pkg::st_idle:
            begin
                if (acc_commit && hit_instr)
                begin
                    st_nxt.fsm = branch_pkg::st_eval;
                    st_nxt.op = wr_merge[`INSTR_OP_LSB +: `OP_W];
                    st_nxt.sidx = wr_merge[`INSTR_SIDX_LSB +: `SIDX_W];
                    st_nxt.koff = wr_merge[`INSTR_KOFF_LSB +: `KOFF_W];
                end
                else if (acc_commit && hit_pc)
                begin
                    st_nxt.pc = wr_merge[`PC_W-1:0];
                end
                else if (acc_commit && hit_flags)
                begin
                    st_nxt.flags = wr_merge[`FLAGS_W-1:0];
                end
            end
            branch_pkg::st_eval:
            begin
                st_nxt.illegal = ~cond_legal;
                st_nxt.taken = cond_taken;
                if (cond_taken)
                begin
                    st_nxt.fsm = branch_pkg::st_load; // RULE16
                    st_nxt.target = tgt_pc; // RULE13
                end
                else
                begin
                    st_nxt.fsm = branch_pkg::st_idle;
                    st_nxt.pc = seq_pc; // RULE16
                    st_nxt.last_cycles = `CYC_NOT_TAKEN; // RULE14
                    st_nxt.done = 1'b1;
                end
            end
            branch_pkg::st_load:
            begin
                st_nxt.fsm = branch_pkg::st_idle;
                st_nxt.pc = st_r.target; // RULE13
                st_nxt.last_cycles = `CYC_TAKEN; // RULE14
                st_nxt.done = 1'b1;
            end
            default:
            begin
                st_nxt.fsm = branch_pkg::st_idle;
            end
        endcase
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= STATE_RST;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pc_out = st_r.pc;
    assign busy = unit_busy;
    assign branch_done = st_r.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic eval_now;
    logic [`PC_W-1:0] tgt_chk;
    logic [`PC_W-1:0] seq_chk;

    // Independent references for the target checks
    assign eval_now = (st_r.fsm == branch_pkg::st_eval);
    assign tgt_chk = st_r.pc + {{(`PC_W - `KOFF_W){st_r.koff[`KOFF_W-1]}}, st_r.koff} + `PC_ONE;
    assign seq_chk = st_r.pc + `PC_ONE;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence eval_taken_s;
        ce && eval_now && cond_taken;
    endsequence

    sequence eval_skip_s;
        ce && eval_now && !cond_taken;
    endsequence

    sequence load_step_s;
        ce && st_r.fsm == branch_pkg::st_load;
    endsequence

    bit_clear_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_bit_clear |-> cond_taken == !st_r.flags[st_r.sidx]) // RULE1
        else $error("bit clear branch decision wrong");
    equal_flag_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_equal |-> cond_taken == st_r.flags[`FLAG_Z]) // RULE2
        else $error("equal branch decision wrong");
    not_equal_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_not_equal |-> cond_taken != st_r.flags[`FLAG_Z]) // RULE3
        else $error("not equal branch decision wrong");
    carry_set_a: assert property (eval_now && (st_r.op == branch_pkg::branch_on_carry_set || st_r.op == branch_pkg::branch_unsigned_lower) |-> cond_taken == st_r.flags[`FLAG_C]) // RULE4
        else $error("carry set branch decision wrong");
    carry_clear_a: assert property (eval_now && (st_r.op == branch_pkg::branch_on_carry_clear || st_r.op == branch_pkg::branch_unsigned_same_or_higher) |-> cond_taken == !st_r.flags[`FLAG_C]) // RULE5
        else $error("carry clear branch decision wrong");
    minus_flag_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_minus |-> cond_taken == st_r.flags[`FLAG_N]) // RULE6
        else $error("minus branch decision wrong");
    plus_flag_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_plus |-> cond_taken == !st_r.flags[`FLAG_N]) // RULE7
        else $error("plus branch decision wrong");
    signed_ge_a: assert property (eval_now && st_r.op == branch_pkg::branch_signed_greater_equal |-> cond_taken == (st_r.flags[`FLAG_N] == st_r.flags[`FLAG_V])) // RULE8
        else $error("signed greater equal decision wrong");
    signed_lt_a: assert property (eval_now && st_r.op == branch_pkg::branch_signed_less |-> cond_taken == (st_r.flags[`FLAG_N] != st_r.flags[`FLAG_V])) // RULE9
        else $error("signed less decision wrong");
    half_set_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_half_carry_set |-> cond_taken == st_r.flags[`FLAG_H]) // RULE10
        else $error("half carry set decision wrong");
    half_clear_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_half_carry_clear |-> cond_taken == !st_r.flags[`FLAG_H]) // RULE11
        else $error("half carry clear decision wrong");
    transfer_set_a: assert property (eval_now && st_r.op == branch_pkg::branch_on_transfer_set |-> cond_taken == st_r.flags[`FLAG_T]) // RULE12
        else $error("transfer set decision wrong");
    target_latch_a: assert property (eval_taken_s |=> st_r.fsm == branch_pkg::st_load && st_r.target == $past(tgt_chk)) // RULE13
        else $error("branch target not latched as pc plus k plus one");
    taken_load_a: assert property (load_step_s |=> st_r.pc == $past(st_r.target) && st_r.done && st_r.last_cycles == `CYC_TAKEN) // RULE16
        else $error("taken branch did not load pc in second cycle");
    skip_one_a: assert property (eval_skip_s |=> st_r.fsm == branch_pkg::st_idle && st_r.pc == $past(seq_chk) && st_r.last_cycles == `CYC_NOT_TAKEN) // RULE16
        else $error("untaken branch did not finish in one cycle");
    done_cycles_a: assert property (st_r.done |-> st_r.last_cycles == `CYC_NOT_TAKEN || st_r.last_cycles == `CYC_TAKEN) // RULE14
        else $error("branch cycle count outside one or two");
    flags_hold_a: assert property (unit_busy |=> $stable(st_r.flags)) // RULE15
        else $error("status flags changed during a branch");
    back_offset_a: assert property (eval_now && st_r.koff[`KOFF_W-1] && st_r.pc > 16'h0040 |-> tgt_pc <= st_r.pc) // RULE17
        else $error("negative offset not sign extended");

endmodule
`default_nettype wire

// ### pkg/branch_cfg.svh
// Offsets, field positions, widths, reset values and cycle counts of the branch unit
`ifndef BRANCH_CFG_SVH
`define BRANCH_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PC_W 16
`define KOFF_W 7
`define FLAGS_W 8
`define SIDX_W 3
`define OP_W 4
`define ADDR_W 12
`define DATA_W 32

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_INSTR 12'h000
`define ADDR_PC 12'h004
`define ADDR_FLAGS 12'h008
`define ADDR_STATUS 12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define INSTR_OP_LSB 0
`define INSTR_SIDX_LSB 4
`define INSTR_KOFF_LSB 8
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define STAT_BUSY 0
`define STAT_TAKEN 1
`define STAT_ILLEGAL 2
`define STAT_CYC_LSB 4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PC_RST 16'h0000
`define FLAGS_RST 8'h00
`define PC_ONE 16'h0001
`define CYC_NONE 2'h0
`define CYC_NOT_TAKEN 2'h1
`define CYC_TAKEN 2'h2
`define INSTR_LANES 4'h3 // Lanes that must be written together on a launch

`endif

// ### pkg/branch_pkg.sv
// Types shared by the conditional branch unit
`include "branch_cfg.svh"

package branch_pkg;

    // Branch operations held in the instruction register
    typedef enum logic [`OP_W-1:0] {
        branch_on_bit_clear,
        branch_on_equal,
        branch_on_not_equal,
        branch_on_carry_set,
        branch_on_carry_clear,
        branch_unsigned_same_or_higher,
        branch_unsigned_lower,
        branch_on_minus,
        branch_on_plus,
        branch_signed_greater_equal,
        branch_signed_less,
        branch_on_half_carry_set,
        branch_on_half_carry_clear,
        branch_on_transfer_set
    } branch_op_e;

    // Execution sequence
    typedef enum logic [1:0] {
        st_idle,
        st_eval,
        st_load
    } exec_state_e;

    // Whole state of the unit
    typedef struct packed {
        exec_state_e fsm;
        logic [`PC_W-1:0] pc;
        logic [`FLAGS_W-1:0] flags;
        logic [`OP_W-1:0] op;
        logic [`SIDX_W-1:0] sidx;
        logic [`KOFF_W-1:0] koff;
        logic [`PC_W-1:0] target;
        logic taken;
        logic illegal;
        logic [1:0] last_cycles;
        logic done;
        logic pready;
        logic pslverr;
        logic [`DATA_W-1:0] prdata;
    } unit_state_s;

endpackage

// ### design/branch_condition_eval.sv
// Condition test of one conditional branch against the status flags
`timescale 1ns/10ps
`default_nettype none
`include "branch_cfg.svh"

module branch_condition_eval (
    input wire logic [`OP_W-1:0] op,
    input wire logic [`SIDX_W-1:0] sidx,
    input wire logic [`FLAGS_W-1:0] flags,
    output logic taken,
    output logic legal
);

    // Select flag test by operation
    always_comb
    begin
        taken = 1'b0;
        legal = 1'b1;
        unique case (op)
            branch_pkg::branch_on_bit_clear: taken = ~flags[sidx]; // RULE1
            branch_pkg::branch_on_equal: taken = flags[`FLAG_Z]; // RULE2
            branch_pkg::branch_on_not_equal: taken = ~flags[`FLAG_Z]; // RULE3
            branch_pkg::branch_on_carry_set: taken = flags[`FLAG_C]; // RULE4
            branch_pkg::branch_unsigned_lower: taken = flags[`FLAG_C]; // RULE4
            branch_pkg::branch_on_carry_clear: taken = ~flags[`FLAG_C]; // RULE5
            branch_pkg::branch_unsigned_same_or_higher: taken = ~flags[`FLAG_C]; // RULE5
            branch_pkg::branch_on_minus: taken = flags[`FLAG_N]; // RULE6
            branch_pkg::branch_on_plus: taken = ~flags[`FLAG_N]; // RULE7
            branch_pkg::branch_signed_greater_equal:
                taken = ~(flags[`FLAG_N] ^ flags[`FLAG_V]); // RULE8
            branch_pkg::branch_signed_less:
                taken = flags[`FLAG_N] ^ flags[`FLAG_V]; // RULE9
            branch_pkg::branch_on_half_carry_set: taken = flags[`FLAG_H]; // RULE10
            branch_pkg::branch_on_half_carry_clear: taken = ~flags[`FLAG_H]; // RULE11
            branch_pkg::branch_on_transfer_set: taken = flags[`FLAG_T]; // RULE12
            default: legal = 1'b0; // Unused codes never branch
        endcase
    end

endmodule
`default_nettype wire

// ### design/branch_target_adder.sv
// Sequential and relative branch target addresses
`timescale 1ns/10ps
`default_nettype none
`include "branch_cfg.svh"

module branch_target_adder (
    input wire logic [`PC_W-1:0] pc,
    input wire logic [`KOFF_W-1:0] koff,
    output logic [`PC_W-1:0] next_seq,
    output logic [`PC_W-1:0] target
);

    logic [`PC_W-1:0] koff_ext;

    // Word displacement, sign extended, wraps at the top of program space
    assign koff_ext = {{(`PC_W - `KOFF_W){koff[`KOFF_W-1]}}, koff}; // RULE17
    assign next_seq = pc + `PC_ONE;
    assign target = pc + koff_ext + `PC_ONE; // RULE13

endmodule
`default_nettype wire

// ### testbench/conditional_branch_unit_tb_top.sv
// Self-checking testbench of the conditional branch unit
`timescale 1ns/10ps
`default_nettype none
`include "branch_cfg.svh"

module conditional_branch_unit_tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct {
        logic [3:0] op;
        logic [2:0] s;
        logic [7:0] fl;
        logic [15:0] pc;
        logic [6:0] k;
        logic tk;
    } row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic [`ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [`DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [`PC_W-1:0] pc_out;
    logic busy;
    logic branch_done;
    logic [31:0] rdat;
    logic rerr;
    int errors = 0;
    int num_checks = 0;
    row_s rows[$];

    // Clock of 8 ns
    always #4 pclk = ~pclk;

    conditional_branch_unit i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_out(pc_out),
        .busy(busy), .branch_done(branch_done)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; waits for pready with a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] st);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            $display("Error at %0t: pready timeout got %h expected %h", $time, 1'b0, 1'b1);
            final_report();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Loads PC and flags, launches one branch, checks timing and results
    task automatic run_row(input row_s r);
        logic [15:0] exp_pc;
        logic ill;
        int nb;
        int n;
        ill = (r.op > 4'hD);
        exp_pc = r.tk ? r.pc + {{9{r.k[6]}}, r.k} + 16'h0001 : r.pc + 16'h0001;
        apb(1'b1, `ADDR_PC, {16'h0000, r.pc}, 4'hF);
        apb(1'b1, `ADDR_FLAGS, {24'h000000, r.fl}, 4'hF);
        apb(1'b1, `ADDR_INSTR, {17'h00000, r.k, 1'b0, r.s, r.op}, 4'hF);
        nb = 0;
        n = 0;
        while (branch_done !== 1'b1 && n < 10)
        begin
            @(negedge pclk);
            n++;
            if (busy === 1'b1)
                nb++;
        end
        if (n >= 10)
        begin
            errors++;
            $display("Error at %0t: branch_done timeout got %h expected %h", $time, 1'b0, 1'b1);
            final_report();
        end
        check({16'h0000, pc_out}, {16'h0000, exp_pc}, "pc_out");
        check(nb, r.tk ? 2 : 1, "busy cycles");
        apb(1'b0, `ADDR_FLAGS, 32'h0, 4'hF);
        check(rdat, {24'h000000, r.fl}, "flags");
        apb(1'b0, `ADDR_STATUS, 32'h0, 4'hF);
        check(rdat & 32'h37, {26'h0, r.tk ? 2'h2 : 2'h1, 1'b0, ill, r.tk, 1'b0}, "status");
    endtask

    task automatic add(input logic [3:0] op, input logic [2:0] s, input logic [7:0] fl,
                       input logic [15:0] pc, input logic [6:0] k, input logic tk);
        rows.push_back('{op, s, fl, pc, k, tk});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        add(4'h0, 3'h3, 8'h08, 16'h0100, 7'h05, 1'b0);
        add(4'h0, 3'h5, 8'hDF, 16'h0010, 7'h40, 1'b1);
        add(4'h1, 3'h0, 8'h02, 16'h0200, 7'h01, 1'b1);
        add(4'h1, 3'h0, 8'hFD, 16'h0200, 7'h01, 1'b0);
        add(4'h2, 3'h0, 8'h00, 16'h0300, 7'h7F, 1'b1);
        add(4'h2, 3'h0, 8'h02, 16'h0300, 7'h7F, 1'b0);
        add(4'h3, 3'h0, 8'h01, 16'h0400, 7'h10, 1'b1);
        add(4'h3, 3'h0, 8'hFE, 16'h0400, 7'h10, 1'b0);
        add(4'h6, 3'h0, 8'h01, 16'h0480, 7'h02, 1'b1);
        add(4'h6, 3'h0, 8'h00, 16'h0480, 7'h02, 1'b0);
        add(4'h4, 3'h0, 8'h00, 16'h0500, 7'h20, 1'b1);
        add(4'h4, 3'h0, 8'h01, 16'h0500, 7'h20, 1'b0);
        add(4'h5, 3'h0, 8'h00, 16'h0580, 7'h03, 1'b1);
        add(4'h5, 3'h0, 8'h01, 16'hFFFF, 7'h03, 1'b0);
        add(4'h7, 3'h0, 8'h04, 16'h0600, 7'h3F, 1'b1);
        add(4'h7, 3'h0, 8'hFB, 16'h0600, 7'h3F, 1'b0);
        add(4'h8, 3'h0, 8'h00, 16'h0700, 7'h7E, 1'b1);
        add(4'h8, 3'h0, 8'h04, 16'h0700, 7'h7E, 1'b0);
        add(4'h9, 3'h0, 8'h0C, 16'h0800, 7'h04, 1'b1);
        add(4'h9, 3'h0, 8'h04, 16'h0800, 7'h04, 1'b0);
        add(4'hA, 3'h0, 8'h08, 16'h0900, 7'h08, 1'b1);
        add(4'hA, 3'h0, 8'h0C, 16'h0900, 7'h08, 1'b0);
        add(4'hB, 3'h0, 8'h20, 16'h0A00, 7'h11, 1'b1);
        add(4'hB, 3'h0, 8'hDF, 16'h0A00, 7'h11, 1'b0);
        add(4'hC, 3'h0, 8'h00, 16'h0B00, 7'h12, 1'b1);
        add(4'hC, 3'h0, 8'h20, 16'h0B00, 7'h12, 1'b0);
        add(4'hD, 3'h0, 8'h40, 16'h0C00, 7'h13, 1'b1);
        add(4'hD, 3'h0, 8'hBF, 16'h0C00, 7'h13, 1'b0);
        add(4'hE, 3'h0, 8'hFF, 16'h0D00, 7'h14, 1'b0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values seen through the bus
        apb(1'b0, `ADDR_PC, 32'h0, 4'hF);
        check(rdat, 32'h0, "pc reset");
        apb(1'b0, `ADDR_STATUS, 32'h0, 4'hF);
        check(rdat & 32'h37, 32'h0, "status reset");
        $display("Test reset values done");
        foreach (rows[i])
            run_row(rows[i]);
        $display("Test branch table done");
        // Refused accesses leave state alone
        apb(1'b0, 12'h010, 32'h0, 4'hF);
        check(rerr, 1'b1, "unmapped read error");
        apb(1'b1, 12'h014, 32'h1234, 4'hF);
        check(rerr, 1'b1, "unmapped write error");
        apb(1'b1, `ADDR_INSTR, 32'h0000_0501, 4'h1);
        check(rerr, 1'b1, "narrow instr error");
        repeat (4) @(negedge pclk);
        check(busy, 1'b0, "no launch on refused write");
        apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
        check(rerr, 1'b0, "status write ignored");
        $display("Test refused accesses done");
        // Clock enable low stretches the answer
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= `ADDR_PC;
        @(posedge pclk);
        penable <= 1'b1;
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        check(pready, 1'b0, "pready frozen");
        ce <= 1'b1;
        // Finish the stalled read once the enable returns
        rdat = 32'h0;
        for (int w = 0; w < 20 && pready !== 1'b1; w++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: stalled pready got %h expected %h", $time, pready, 1'b1);
            final_report();
        end
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        check(rdat, 32'h0000_0D01, "stalled pc read");
        apb(1'b0, `ADDR_PC, 32'h0, 4'hF);
        check(rdat, 32'h0000_0D01, "pc after stall");
        $display("Test clock enable done");
        // Reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({busy, branch_done, pready}, 3'h0, "outputs in reset");
        check({16'h0000, pc_out}, 32'h0, "pc in reset");
        presetn <= 1'b1;
        apb(1'b0, `ADDR_PC, 32'h0, 4'hF);
        check(rdat, 32'h0, "pc read after second reset");
        apb(1'b0, `ADDR_STATUS, 32'h0, 4'hF);
        check(rdat & 32'h37, 32'h0, "status after second reset");
        $display("Test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
